// File: logic/opaddr_pkg.sv
// Shared constants and types for the operand address generator.
// Assumes a single core clock domain; nothing here holds logic.
package opaddr_pkg;

    // Addressing mode presented by the instruction decoder
    typedef enum logic [2:0] {
        immediate_mode = 3'b000,
        direct_mode = 3'b001,
        indirect_mode = 3'b010,
        indirect16_mode = 3'b011,
        register_mode = 3'b100,
        implicit_mode = 3'b101,
        index_read_mode = 3'b110,
        index_jump_mode = 3'b111
    } mode_t;

    // Space in which the resolved operand lives
    typedef enum logic [2:0] {
        space_none = 3'b000,
        space_code = 3'b001,
        space_iram = 3'b010,
        space_sfr = 3'b011,
        space_xram = 3'b100,
        space_acc = 3'b101,
        space_data_pointer_16 = 3'b110
    } space_t;

    // Pointer select for 8-bit indirect access
    localparam logic [1:0] PTR_BANK_REG_ZERO = 2'h0;
    localparam logic [1:0] PTR_BANK_REG_ONE = 2'h1;
    localparam logic [1:0] PTR_STACK = 2'h2;

    // Base select for indexed access
    localparam logic BASE_DATA_POINTER = 1'b0;
    localparam logic BASE_PC = 1'b1;

    // Implied register select
    localparam logic IMPL_ACC = 1'b0;
    localparam logic IMPL_DATA_POINTER_16 = 1'b1;

    // Field positions and limits
    localparam int BANK_SHIFT = 3;
    localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
    localparam logic [15:0] OPCODE_STEP = 16'h0001;

    // Reset values
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic RST_FLAG = 1'b0;
endpackage

// File: logic/operand_address_generator.sv
// Operand address generator of the 8-bit core.
// Assumes decoder, register file and program counter all run on
// i_clk_sys; every input is taken in the cycle i_req and i_ce are both high.
`timescale 1ns/10ps

// Operation
// RL1: Immediate operand is read from code memory right after the opcode.
// RL2: Direct operand address comes from an 8-bit instruction field.
// RL3: Direct reaches only low 128 RAM bytes and the special registers.
// RL4: Indirect takes the address from a pointer; internal or external RAM.
// RL5: 8-bit indirect pointer is bank register zero, one, or stack pointer.
// RL6: 16-bit indirect pointer is only the 16-bit data pointer.
// RL7: Register mode decodes a 3-bit opcode field into the active bank.
// RL8: Implied operand is accumulator or data pointer, with no address byte.
// RL9: Indexed access reads code memory only; writes are refused.
// RL10: Indexed read address is 16-bit base plus accumulator.
// RL11: Indexed jump loads program counter with base plus accumulator.
// RL12: Two-bit bank select places bank registers at the bank base.
module operand_address_generator (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_req,
    input wire logic [2:0] i_mode,
    input wire logic i_is_write,
    input wire logic [7:0] i_addr_byte,
    input wire logic [2:0] i_reg_field,
    input wire logic [1:0] i_ptr_sel,
    input wire logic i_ext,
    input wire logic i_base_sel,
    input wire logic i_impl_sel,
    input wire logic [1:0] i_bank_sel,
    input wire logic [7:0] i_bank_reg_zero,
    input wire logic [7:0] i_bank_reg_one,
    input wire logic [7:0] i_sp,
    input wire logic [15:0] i_data_pointer_16,
    input wire logic [15:0] i_pc,
    input wire logic [7:0] i_acc,
    output logic o_valid,
    output logic [2:0] o_space,
    output logic [15:0] o_addr,
    output logic o_addr_byte,
    output logic o_pc_load,
    output logic [15:0] o_pc_value,
    output logic o_error
);

    // Base plus unsigned 8-bit offset, wrapping at 16 bits
    function automatic logic [15:0] add_off(input logic [15:0] base,
                                            input logic [7:0] off);
        add_off = base + {8'h00, off};
    endfunction

    // Internal RAM address of a bank register
    function automatic logic [15:0] bank_addr(input logic [1:0] bank,
                                              input logic [2:0] idx);
        bank_addr = {8'h00, 3'h0, bank, idx};
    endfunction

    logic next_valid;
    logic [2:0] next_space;
    logic [15:0] next_addr;
    logic next_addr_byte;
    logic next_pc_load;
    logic [15:0] next_pc_value;
    logic next_error;
    logic [15:0] index_base;

    // Decode of the requested mode into space and address
    always_comb begin
        index_base = (i_base_sel == opaddr_pkg::BASE_PC) ?
                     i_pc : i_data_pointer_16;
        next_valid = i_req;
        next_space = o_space;
        next_addr = o_addr;
        next_addr_byte = o_addr_byte;
        next_pc_load = opaddr_pkg::RST_FLAG;
        next_pc_value = o_pc_value;
        next_error = opaddr_pkg::RST_FLAG;
        if (i_req) begin
            next_space = opaddr_pkg::space_none;
            next_addr = opaddr_pkg::RST_ADDR;
            next_addr_byte = 1'b0;
            case (i_mode)
                opaddr_pkg::immediate_mode: begin
                    // Constant sits in code right after the opcode
                    next_space = opaddr_pkg::space_code; // RL1
                    next_addr = add_off(i_pc, 8'h00) + // RL1
                                opaddr_pkg::OPCODE_STEP;
                    next_error = i_is_write;
                end
                opaddr_pkg::direct_mode: begin
                    // Low half is RAM, upper half is special registers
                    next_addr = {8'h00, i_addr_byte}; // RL2
                    next_addr_byte = 1'b1; // RL2
                    next_space = (i_addr_byte < // RL3
                                  opaddr_pkg::DIRECT_SFR_BASE) ?
                                 opaddr_pkg::space_iram :
                                 opaddr_pkg::space_sfr;
                end
                opaddr_pkg::indirect_mode: begin
                    // Pointer value names internal or external RAM
                    next_space = i_ext ? opaddr_pkg::space_xram : // RL4
                                 opaddr_pkg::space_iram;
                    case (i_ptr_sel)
                        opaddr_pkg::PTR_BANK_REG_ZERO: begin
                            next_addr = {8'h00, i_bank_reg_zero}; // RL5
                        end
                        opaddr_pkg::PTR_BANK_REG_ONE: begin
                            next_addr = {8'h00, i_bank_reg_one}; // RL5
                        end
                        opaddr_pkg::PTR_STACK: begin
                            next_addr = {8'h00, i_sp}; // RL5
                        end
                        default: begin
                            // No other 8-bit pointer exists
                            next_space = opaddr_pkg::space_none; // RL5
                            next_error = 1'b1;
                        end
                    endcase
                end
                opaddr_pkg::indirect16_mode: begin
                    // Only the data pointer forms a 16-bit address
                    next_space = opaddr_pkg::space_xram; // RL6
                    next_addr = i_data_pointer_16; // RL6
                end
                opaddr_pkg::register_mode: begin
                    // Bank register lives at bank base plus field
                    next_space = opaddr_pkg::space_iram; // RL7
                    next_addr = bank_addr(i_bank_sel, i_reg_field); // RL12
                end
                opaddr_pkg::implicit_mode: begin
                    // The opcode alone names the register
                    next_space = (i_impl_sel == opaddr_pkg::IMPL_DATA_POINTER_16) ?
                                 opaddr_pkg::space_data_pointer_16 : // RL8
                                 opaddr_pkg::space_acc;
                end
                opaddr_pkg::index_read_mode: begin
                    // Table lookup in code memory, read only
                    if (i_is_write) begin
                        next_error = 1'b1; // RL9
                    end else begin
                        next_space = opaddr_pkg::space_code; // RL9
                        next_addr = add_off(index_base, i_acc); // RL10
                    end
                end
                opaddr_pkg::index_jump_mode: begin
                    // Computed branch target
                    if (i_is_write) begin
                        next_error = 1'b1; // RL9
                    end else begin
                        next_pc_load = 1'b1; // RL11
                        next_pc_value = add_off(index_base, i_acc); // RL11
                    end
                end
                default: begin
                    next_error = 1'b1;
                end
            endcase
        end
    end

    // Result registers, frozen while the clock enable is low
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_valid <= opaddr_pkg::RST_FLAG;
            o_space <= opaddr_pkg::space_none;
            o_addr <= opaddr_pkg::RST_ADDR;
            o_addr_byte <= opaddr_pkg::RST_FLAG;
            o_pc_load <= opaddr_pkg::RST_FLAG;
            o_pc_value <= opaddr_pkg::RST_ADDR;
            o_error <= opaddr_pkg::RST_FLAG;
        end else if (i_ce) begin
            o_valid <= next_valid;
            o_space <= next_space;
            o_addr <= next_addr;
            o_addr_byte <= next_addr_byte;
            o_pc_load <= next_pc_load;
            o_pc_value <= next_pc_value;
            o_error <= next_error;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_req(logic [2:0] m);
        i_ce && i_req && i_mode == m;
    endsequence

    property p_imm;
        s_req(opaddr_pkg::immediate_mode) |=>
            o_space == opaddr_pkg::space_code &&
            o_addr == $past(i_pc) + 16'h0001 && !o_addr_byte;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate address bad"); // RL1

    property p_dir;
        s_req(opaddr_pkg::direct_mode) |=>
            o_addr == {8'h00, $past(i_addr_byte)} && o_addr_byte;
    endproperty
    a_dir: assert property (p_dir) else $error("direct address bad"); // RL2

    property p_dir_space;
        s_req(opaddr_pkg::direct_mode) ##1 o_addr[7] == 1'b0 |->
            o_space == opaddr_pkg::space_iram;
    endproperty
    a_dir_space: assert property (p_dir_space) // RL3
        else $error("low direct byte not in RAM");

    property p_dir_sfr;
        s_req(opaddr_pkg::direct_mode) ##1 o_addr[7] |->
            o_space == opaddr_pkg::space_sfr;
    endproperty
    a_dir_sfr: assert property (p_dir_sfr) // RL3
        else $error("upper direct byte not special register");

    property p_ind;
        s_req(opaddr_pkg::indirect_mode) ##0 (i_ptr_sel == 2'h1) |=>
            o_addr == {8'h00, $past(i_bank_reg_one)} &&
            o_space == ($past(i_ext) ? opaddr_pkg::space_xram :
                        opaddr_pkg::space_iram);
    endproperty
    a_ind: assert property (p_ind) else $error("indirect pointer bad"); // RL4

    property p_ind_sp;
        s_req(opaddr_pkg::indirect_mode) ##0 (i_ptr_sel == 2'h2) |=>
            o_addr == {8'h00, $past(i_sp)} && !o_error;
    endproperty
    a_ind_sp: assert property (p_ind_sp) // RL5
        else $error("stack pointer indirect bad");

    // Pointer code three names no register and is refused
    property p_ind_bad;
        s_req(opaddr_pkg::indirect_mode) ##0 (i_ptr_sel == 2'h3) |=>
            o_error && o_space == opaddr_pkg::space_none;
    endproperty
    a_ind_bad: assert property (p_ind_bad) // RL5
        else $error("illegal pointer not refused");

    property p_ind16;
        s_req(opaddr_pkg::indirect16_mode) |=>
            o_addr == $past(i_data_pointer_16) &&
            o_space == opaddr_pkg::space_xram;
    endproperty
    a_ind16: assert property (p_ind16) // RL6
        else $error("16-bit pointer bad");

    property p_reg;
        s_req(opaddr_pkg::register_mode) |=>
            o_addr == {8'h00, 3'h0, $past(i_bank_sel), $past(i_reg_field)};
    endproperty
    a_reg: assert property (p_reg) else $error("bank register bad"); // RL7

    property p_impl;
        s_req(opaddr_pkg::implicit_mode) |=> !o_addr_byte &&
            o_space == ($past(i_impl_sel) ? opaddr_pkg::space_data_pointer_16 :
                        opaddr_pkg::space_acc);
    endproperty
    a_impl: assert property (p_impl) // RL8
        else $error("implied register bad");

    property p_idx_wr;
        s_req(opaddr_pkg::index_read_mode) ##0 (i_is_write) |=>
            o_error && o_space != opaddr_pkg::space_code;
    endproperty
    a_idx_wr: assert property (p_idx_wr) // RL9
        else $error("indexed write not refused");

    property p_idx_rd;
        s_req(opaddr_pkg::index_read_mode) ##0 (!i_is_write) |=>
            o_addr == ($past(i_base_sel) ? $past(i_pc) :
                       $past(i_data_pointer_16)) + {8'h00, $past(i_acc)};
    endproperty
    a_idx_rd: assert property (p_idx_rd) // RL10
        else $error("indexed read address bad");

    property p_jmp;
        s_req(opaddr_pkg::index_jump_mode) ##0 (!i_is_write) |=>
            o_pc_load && o_valid && !o_error;
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump not loaded"); // RL11

    property p_jmp_val;
        s_req(opaddr_pkg::index_jump_mode) ##0 (!i_is_write) |=>
            o_pc_value == ($past(i_base_sel) ? $past(i_pc) :
                           $past(i_data_pointer_16)) + {8'h00, $past(i_acc)};
    endproperty
    a_jmp_val: assert property (p_jmp_val) // RL11
        else $error("jump target bad");

    // A load stands only after a jump request or frozen by a low enable
    property p_load_pulse;
        o_pc_load |->
            ($past(o_pc_load) && !$past(i_ce)) ||
            ($past(i_ce) && $past(i_req) && !$past(i_is_write) &&
             $past(i_mode) == opaddr_pkg::index_jump_mode);
    endproperty
    a_load_pulse: assert property (p_load_pulse) // RL11
        else $error("stray program counter load");

    property p_bank;
        s_req(opaddr_pkg::register_mode) |=>
            o_addr[4:3] == $past(i_bank_sel) && o_addr[15:5] == 11'h000;
    endproperty
    a_bank: assert property (p_bank) else $error("bank base bad"); // RL12

endmodule

// File: test/tb.sv
// Self-checking bench for the operand address generator.
// Assumes one answer per enabled edge; a model predicts every output.
`timescale 1ns/10ps
module tb;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b0;
    logic i_req = 1'b0;
    logic [2:0] i_mode = 3'h0;
    logic i_is_write = 1'b0;
    logic [7:0] i_addr_byte = 8'h00;
    logic [2:0] i_reg_field = 3'h0;
    logic [1:0] i_ptr_sel = 2'h0;
    logic i_ext = 1'b0;
    logic i_base_sel = 1'b0;
    logic i_impl_sel = 1'b0;
    logic [1:0] i_bank_sel = 2'h0;
    logic [7:0] i_bank_reg_zero = 8'h00;
    logic [7:0] i_bank_reg_one = 8'h00;
    logic [7:0] i_sp = 8'h00;
    logic [15:0] i_data_pointer_16 = 16'h0000;
    logic [15:0] i_pc = 16'h0000;
    logic [7:0] i_acc = 8'h00;
    logic o_valid, o_addr_byte, o_pc_load, o_error;
    logic [2:0] o_space;
    logic [15:0] o_addr, o_pc_value;
    // Expected outputs of the model
    logic e_valid = 1'b0, e_ab = 1'b0, e_pcl = 1'b0, e_err = 1'b0;
    logic [2:0] e_space = 3'h0, e_mode = 3'h0;
    logic [15:0] e_addr = 16'h0000, e_pcv = 16'h0000;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed_ret;

    operand_address_generator uut (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_req(i_req), .i_mode(i_mode), .i_is_write(i_is_write),
        .i_addr_byte(i_addr_byte), .i_reg_field(i_reg_field),
        .i_ptr_sel(i_ptr_sel), .i_ext(i_ext), .i_base_sel(i_base_sel),
        .i_impl_sel(i_impl_sel), .i_bank_sel(i_bank_sel),
        .i_bank_reg_zero(i_bank_reg_zero), .i_bank_reg_one(i_bank_reg_one),
        .i_sp(i_sp), .i_data_pointer_16(i_data_pointer_16), .i_pc(i_pc),
        .i_acc(i_acc), .o_valid(o_valid), .o_space(o_space),
        .o_addr(o_addr), .o_addr_byte(o_addr_byte), .o_pc_load(o_pc_load),
        .o_pc_value(o_pc_value), .o_error(o_error)
    );

    // Clock and hang guard
    always #50 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // Compare all outputs with the model
    task automatic check_all();
        check({15'h0, o_valid}, {15'h0, e_valid});
        check({15'h0, o_addr_byte}, {15'h0, e_ab});
        check({15'h0, o_error}, {15'h0, e_err});
        check({15'h0, o_pc_load}, {15'h0, e_pcl});
        check(o_pc_value, e_pcv);
        case (e_mode)
            3'h0: check(o_addr, e_addr);
            3'h1: check(o_addr, e_addr);
            3'h2: check(o_addr, e_addr);
            3'h3: check(o_addr, e_addr);
            3'h4: check(o_addr, e_addr);
            3'h5: check(o_addr, e_addr);
            3'h6: check(o_addr, e_addr);
            default: check(o_addr, e_addr);
        endcase
        check({13'h0, o_space}, {13'h0, e_space});
    endtask

    // Model of the edge that follows the current inputs
    task automatic model_edge();
        logic [15:0] base;
        logic [7:0] ptr;
        base = i_base_sel ? i_pc : i_data_pointer_16;
        ptr = (i_ptr_sel == 2'h0) ? i_bank_reg_zero :
              (i_ptr_sel == 2'h1) ? i_bank_reg_one : i_sp;
        if (!i_ce) begin
            return;
        end
        e_valid = i_req;
        e_pcl = 1'b0;
        e_err = 1'b0;
        if (!i_req) begin
            return;
        end
        e_mode = i_mode;
        e_ab = 1'b0;
        e_addr = 16'h0000;
        e_space = opaddr_pkg::space_none;
        case (i_mode)
            3'h0: begin
                e_space = opaddr_pkg::space_code;
                e_addr = i_pc + 16'h0001;
                e_err = i_is_write;
            end
            3'h1: begin
                e_ab = 1'b1;
                e_addr = {8'h00, i_addr_byte};
                e_space = i_addr_byte[7] ? opaddr_pkg::space_sfr
                                         : opaddr_pkg::space_iram;
            end
            3'h2: begin
                e_err = (i_ptr_sel == 2'h3);
                e_addr = e_err ? 16'h0000 : {8'h00, ptr};
                e_space = e_err ? opaddr_pkg::space_none :
                          i_ext ? opaddr_pkg::space_xram
                                : opaddr_pkg::space_iram;
            end
            3'h3: begin
                e_addr = i_data_pointer_16;
                e_space = opaddr_pkg::space_xram;
            end
            3'h4: begin
                e_addr = {11'h000, i_bank_sel, i_reg_field};
                e_space = opaddr_pkg::space_iram;
            end
            3'h5: begin
                e_space = i_impl_sel ? opaddr_pkg::space_data_pointer_16
                                     : opaddr_pkg::space_acc;
            end
            3'h6: begin
                e_err = i_is_write;
                e_addr = e_err ? 16'h0000 : base + {8'h00, i_acc};
                e_space = e_err ? opaddr_pkg::space_none
                                : opaddr_pkg::space_code;
            end
            default: begin
                e_err = i_is_write;
                e_pcl = !i_is_write;
                if (!i_is_write) begin
                    e_pcv = base + {8'h00, i_acc};
                end
            end
        endcase
    endtask

    // Random operands; pointer code 3 only where it is meaningful
    task automatic rand_in();
        {i_is_write, i_addr_byte, i_reg_field, i_ptr_sel, i_ext} =
            15'($urandom);
        {i_base_sel, i_impl_sel, i_bank_sel, i_acc} = 12'($urandom);
        {i_bank_reg_zero, i_bank_reg_one, i_sp} = 24'($urandom);
        {i_data_pointer_16, i_pc} = $urandom;
        i_mode = 3'($urandom);
    endtask

    task automatic step(input logic ce, input logic req);
        @(negedge i_clk_sys);
        check_all();
        i_ce = ce;
        i_req = req;
    endtask

    task automatic settle();
        if (i_mode != 3'h2 && i_ptr_sel == 2'h3) begin
            i_ptr_sel = 2'h0;
        end
        model_edge();
    endtask

    // Main sequence
    initial begin
        seed_ret = $urandom(32'ha1aa);
        repeat (4) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        // Every mode against both directions and pointer codes 0 to 2; code 3 in indirect mode only
        for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 8; k++) begin
                step(1'b1, 1'b1);
                rand_in();
                i_mode = 3'(m);
                i_is_write = k[2];
                i_ptr_sel = k[1:0];
                settle();
            end
        end
        // Jump target wraps at 16 bits
        step(1'b1, 1'b1);
        i_mode = 3'h7;
        i_is_write = 1'b0;
        i_base_sel = 1'b0;
        i_data_pointer_16 = 16'hfff0;
        i_acc = 8'h20;
        settle();
        // Random traffic with stalls and idle cycles
        for (int n = 0; n < 2000; n++) begin
            step(($urandom % 8) != 0, ($urandom % 4) != 0);
            rand_in();
            settle();
            if (n == 1000) begin
                i_rst_b = 1'b0;
                i_req = 1'b0;
                {e_valid, e_ab, e_pcl, e_err, e_space, e_mode} = 10'h000;
                e_addr = 16'h0000;
                e_pcv = 16'h0000;
                step(1'b1, 1'b0);
                i_rst_b = 1'b1;
            end
        end
        step(1'b1, 1'b0);
        give_verdict();
    end
endmodule
